// ===== hw/svsx_pkg.sv
// Constants and types shared by the Service Mode save and exit command handler
package svsx_pkg;

  // ASCII characters seen on the command line
  localparam logic [7:0] CHAR_CR             = 8'h0d;
  localparam logic [7:0] CHAR_LF             = 8'h0a;
  localparam logic [7:0] CHAR_SPACE          = 8'h20;
  localparam logic [7:0] CHAR_COMMA          = 8'h2c;
  localparam logic [7:0] CHAR_NONE           = 8'h00;
  localparam logic [7:0] CHAR_CMD_SAVE       = 8'h73;
  localparam logic [7:0] CHAR_CMD_EXIT       = 8'h78;
  localparam logic [7:0] CHAR_YES            = 8'h59;
  localparam logic [7:0] CHAR_NO             = 8'h4e;
  localparam logic [7:0] CHAR_EXIT_NORMAL    = 8'h6e;
  localparam logic [7:0] CHAR_EXIT_INIT      = 8'h69;
  localparam logic [7:0] CHAR_EXIT_NORMAL_NOW = 8'h4e;
  localparam logic [7:0] CHAR_EXIT_INIT_NOW  = 8'h49;

  // Line parser layout
  localparam int unsigned    EXTRA_W         = 3;
  localparam logic [2:0]     EXTRA_NONE      = 3'h0;
  localparam logic [2:0]     EXTRA_EXIT      = 3'h2;
  localparam logic [2:0]     EXTRA_MAX       = 3'h7;
  localparam logic [2:0]     POS_FIRST       = 3'h0;
  localparam logic [2:0]     POS_SECOND      = 3'h1;
  localparam logic [2:0]     POS_THIRD       = 3'h2;

  // Save counter
  localparam int unsigned    COUNT_W         = 16;
  localparam logic [15:0]    SAVE_COUNT_RESET = 16'h0000;
  localparam logic [15:0]    SAVE_COUNT_MAX  = 16'h2710;
  localparam logic [15:0]    SAVE_COUNT_SAT  = 16'hffff;

  // Exit hold time
  localparam int unsigned    CLOCK_HZ        = 125000000;
  localparam int unsigned    HOLD_TIME_S     = 3;
  localparam int unsigned    HOLD_CYCLES     = HOLD_TIME_S * CLOCK_HZ;
  localparam int unsigned    HOLD_W          = 32;

  typedef enum logic [3:0] {
    MSG_PROMPT,
    MSG_SAVE_CONFIRM,
    MSG_SAVE_STORED,
    MSG_SAVE_COUNT,
    MSG_SAVE_ABORTED,
    MSG_EXIT_CONFIRM,
    MSG_RETURN_NORMAL,
    MSG_RETURN_INIT,
    MSG_ERR_UNKNOWN_CMD,
    MSG_ERR_PARAM_COUNT,
    MSG_ERR_INVALID_PARAM,
    MSG_WARN_MAX_SAVES,
    MSG_ERR_SAVE_FAILED
  } svsx_msg_e;

endpackage

// ===== hw/svsx_line_parser.sv
// Collects one command line and reports its first three characters and how many characters follow the first
`timescale 1ns/1ps
module svsx_line_parser (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Received characters
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  // Completed line
  output logic            o_line_valid,
  output logic [7:0]      o_first,
  output logic [7:0]      o_second,
  output logic [7:0]      o_third,
  output logic [2:0]      o_extra
);

  logic [2:0] pos;
  logic [7:0] c0;
  logic [7:0] c1;
  logic [7:0] c2;

  // Line feeds are dropped so that CR LF terminals behave like CR only
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pos <= svsx_pkg::POS_FIRST;
      c0  <= svsx_pkg::CHAR_NONE;
      c1  <= svsx_pkg::CHAR_NONE;
      c2  <= svsx_pkg::CHAR_NONE;
    end else if (i_rx_valid && i_rx_data == svsx_pkg::CHAR_CR) begin
      pos <= svsx_pkg::POS_FIRST;
      c0  <= svsx_pkg::CHAR_NONE;
      c1  <= svsx_pkg::CHAR_NONE;
      c2  <= svsx_pkg::CHAR_NONE;
    end else if (i_rx_valid && i_rx_data != svsx_pkg::CHAR_LF) begin
      if (pos == svsx_pkg::POS_FIRST) begin
        c0 <= i_rx_data;
      end
      if (pos == svsx_pkg::POS_SECOND) begin
        c1 <= i_rx_data;
      end
      if (pos == svsx_pkg::POS_THIRD) begin
        c2 <= i_rx_data;
      end
      if (pos != svsx_pkg::EXTRA_MAX) begin
        pos <= pos + 3'h1;
      end
    end
  end

  // Length saturates, which is enough to tell one argument from too many
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_line_valid <= 1'b0;
      o_first      <= svsx_pkg::CHAR_NONE;
      o_second     <= svsx_pkg::CHAR_NONE;
      o_third      <= svsx_pkg::CHAR_NONE;
      o_extra      <= svsx_pkg::EXTRA_NONE;
    end else begin
      o_line_valid <= i_rx_valid && i_rx_data == svsx_pkg::CHAR_CR;
      if (i_rx_valid && i_rx_data == svsx_pkg::CHAR_CR) begin
        o_first  <= c0;
        o_second <= c1;
        o_third  <= c2;
        o_extra  <= (pos == svsx_pkg::POS_FIRST) ? svsx_pkg::EXTRA_NONE : pos - 3'h1;
      end
    end
  end

endmodule

// ===== hw/svsx_hold_timer.sv
// Counts the hold time between the exit response and the mode change
`timescale 1ns/1ps
module svsx_hold_timer #(
  parameter int unsigned P_CYCLES = svsx_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // Control
  input  wire logic i_start,
  output logic      o_done
);

  logic [31:0] remaining;
  logic        busy;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      remaining <= 32'h0000_0000;
      busy      <= 1'b0;
      o_done    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        remaining <= 32'(P_CYCLES) - 32'h0000_0001;
        busy      <= 1'b1;
      end else if (busy && remaining == 32'h0000_0000) begin
        busy   <= 1'b0;
        o_done <= 1'b1;
      end else if (busy) begin
        remaining <= remaining - 32'h0000_0001;
      end
    end
  end

endmodule

// ===== hw/svsx_cmd_handler.sv
// Service Mode save and exit command handler
`timescale 1ns/1ps
// Operation
// - A confirmed save writes the live configuration into flash.
// - Count completed saves; warn once the count passes the endurance figure.
// - Every confirmed save attempts the flash write whatever the counter holds.
// - Save asks for confirmation; only upper-case Y proceeds, anything else aborts.
// - Unconfirmed save with changed serial settings reverts them to stored values.
// - Save with any characters before carriage return gives parameter-count error.
// - Failed flash transfer reports a save-failure error.
// - Unknown command and out-of-range parameter each give their own error.
// - Save reply other than Y or N aborts and reports invalid parameter.
// - Successful save confirms storage, reports save total, then prompt.
// - Argument n exits to Normal Mode, confirming on mismatch, after hold time.
// - Argument i exits to Init Mode, confirming on mismatch, after hold time.
// - Entering Init Mode reloads parameters from flash, dropping unsaved changes.
// - Argument N goes to Normal Mode at once, no confirmation, no hold.
// - Argument I goes to Init Mode at once, no confirmation, no hold.
// - Exit confirmation answered N stays in Service Mode and prompts again.
// - Exit confirmation reply other than Y or N gives invalid parameter.
// - Exit with wrong argument count or leading comma gives parameter-count error.
// - An accepted exit first announces the destination mode.
module svsx_cmd_handler #(
  parameter int unsigned P_HOLD_CYCLES = svsx_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  // Received command characters, same clock domain
  input  wire logic              i_rx_valid,
  input  wire logic [7:0]        i_rx_data,
  // Mode and configuration status
  input  wire logic              i_enter_service,
  input  wire logic              i_params_differ,
  input  wire logic              i_tx_changed,
  input  wire logic              i_count_load,
  input  wire logic [15:0]       i_count_value,
  // Flash
  output logic                   o_flash_write,
  input  wire logic              i_flash_done,
  input  wire logic              i_flash_ok,
  // Responses
  output logic                   o_msg_valid,
  output svsx_pkg::svsx_msg_e    o_msg,
  output logic [15:0]            o_save_count,
  // Mode actions
  output logic                   o_revert_tx,
  output logic                   o_goto_normal,
  output logic                   o_goto_init,
  output logic                   o_reload_flash,
  output logic                   o_in_service
);

  typedef enum logic [3:0] {
    ST_OUT, ST_IDLE, ST_SAVE_CONF, ST_FLASH, ST_SAVE_COUNT, ST_SAVE_WARN,
    ST_ERR_PARAM, ST_PROMPT, ST_EXIT_CONF, ST_HOLD, ST_EXIT
  } svsx_state_e;

  svsx_state_e         state;
  svsx_state_e         next_state;
  logic                next_msg_valid;
  svsx_pkg::svsx_msg_e next_msg;
  logic                next_flash_write;
  logic                next_revert_tx;
  logic                next_count_inc;
  logic                next_hold_start;
  logic                next_goto;
  logic                next_exit_init;
  logic                exit_init;
  logic                line_valid;
  logic [7:0]          first;
  logic [7:0]          second;
  logic [7:0]          third;
  logic [2:0]          extra;
  logic                hold_done;

  svsx_line_parser u_parser (
    .i_clock      (i_clock),
    .i_rst        (i_rst),
    .i_rx_valid   (i_rx_valid),
    .i_rx_data    (i_rx_data),
    .o_line_valid (line_valid),
    .o_first      (first),
    .o_second     (second),
    .o_third      (third),
    .o_extra      (extra)
  );

  svsx_hold_timer #(
    .P_CYCLES (P_HOLD_CYCLES)
  ) u_hold (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_start (next_hold_start),
    .o_done  (hold_done)
  );

  // A reply is one character only; "Yes" is not a yes
  function automatic logic reply_is(input logic [7:0] c, input logic [2:0] n, input logic [7:0] want);
    reply_is = (c == want) && (n == svsx_pkg::EXTRA_NONE);
  endfunction

  always_comb begin
    next_state       = state;
    next_msg_valid   = 1'b0;
    next_msg         = o_msg;
    next_flash_write = 1'b0;
    next_revert_tx   = 1'b0;
    next_count_inc   = 1'b0;
    next_hold_start  = 1'b0;
    next_goto        = 1'b0;
    next_exit_init   = exit_init;
    case (state)
      ST_OUT: begin
        if (i_enter_service) begin
          next_msg_valid = 1'b1;
          next_msg       = svsx_pkg::MSG_PROMPT;
          next_state     = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (line_valid) begin
          next_msg_valid = 1'b1;
          next_state     = ST_PROMPT;
          if (first == svsx_pkg::CHAR_CMD_SAVE) begin
            if (extra == svsx_pkg::EXTRA_NONE) begin
              next_msg   = svsx_pkg::MSG_SAVE_CONFIRM;
              next_state = ST_SAVE_CONF;
            end else begin
              next_msg = svsx_pkg::MSG_ERR_PARAM_COUNT;
            end
          end else if (first == svsx_pkg::CHAR_CMD_EXIT) begin
            if (extra != svsx_pkg::EXTRA_EXIT || second != svsx_pkg::CHAR_SPACE) begin
              next_msg = svsx_pkg::MSG_ERR_PARAM_COUNT;
            end else if (third == svsx_pkg::CHAR_EXIT_NORMAL || third == svsx_pkg::CHAR_EXIT_INIT) begin
              next_exit_init = (third == svsx_pkg::CHAR_EXIT_INIT);
              if (i_params_differ) begin
                next_msg   = svsx_pkg::MSG_EXIT_CONFIRM;
                next_state = ST_EXIT_CONF;
              end else begin
                next_msg        = next_exit_init ? svsx_pkg::MSG_RETURN_INIT : svsx_pkg::MSG_RETURN_NORMAL;
                next_hold_start = 1'b1;
                next_state      = ST_HOLD;
              end
            end else if (third == svsx_pkg::CHAR_EXIT_NORMAL_NOW || third == svsx_pkg::CHAR_EXIT_INIT_NOW) begin
              next_exit_init = (third == svsx_pkg::CHAR_EXIT_INIT_NOW);
              next_msg       = next_exit_init ? svsx_pkg::MSG_RETURN_INIT : svsx_pkg::MSG_RETURN_NORMAL;
              next_state     = ST_EXIT;
            end else begin
              next_msg = svsx_pkg::MSG_ERR_INVALID_PARAM;
            end
          end else begin
            next_msg = svsx_pkg::MSG_ERR_UNKNOWN_CMD;
          end
        end
      end
      ST_SAVE_CONF: begin
        if (line_valid) begin
          if (reply_is(first, extra, svsx_pkg::CHAR_YES)) begin
            next_flash_write = 1'b1;
            next_state       = ST_FLASH;
          end else begin
            next_revert_tx = i_tx_changed;
            next_msg_valid = 1'b1;
            next_msg       = svsx_pkg::MSG_SAVE_ABORTED;
            next_state     = reply_is(first, extra, svsx_pkg::CHAR_NO) ? ST_PROMPT : ST_ERR_PARAM;
          end
        end
      end
      ST_FLASH: begin
        if (i_flash_done) begin
          next_msg_valid = 1'b1;
          if (i_flash_ok) begin
            next_count_inc = 1'b1;
            next_msg       = svsx_pkg::MSG_SAVE_STORED;
            next_state     = ST_SAVE_COUNT;
          end else begin
            next_msg   = svsx_pkg::MSG_ERR_SAVE_FAILED;
            next_state = ST_PROMPT;
          end
        end
      end
      ST_SAVE_COUNT: begin
        next_msg_valid = 1'b1;
        next_msg       = svsx_pkg::MSG_SAVE_COUNT;
        next_state     = (o_save_count > svsx_pkg::SAVE_COUNT_MAX) ? ST_SAVE_WARN : ST_PROMPT;
      end
      ST_SAVE_WARN: begin
        next_msg_valid = 1'b1;
        next_msg       = svsx_pkg::MSG_WARN_MAX_SAVES;
        next_state     = ST_PROMPT;
      end
      ST_ERR_PARAM: begin
        next_msg_valid = 1'b1;
        next_msg       = svsx_pkg::MSG_ERR_INVALID_PARAM;
        next_state     = ST_PROMPT;
      end
      ST_PROMPT: begin
        next_msg_valid = 1'b1;
        next_msg       = svsx_pkg::MSG_PROMPT;
        next_state     = ST_IDLE;
      end
      ST_EXIT_CONF: begin
        if (line_valid) begin
          next_msg_valid = 1'b1;
          if (reply_is(first, extra, svsx_pkg::CHAR_YES)) begin
            next_msg        = exit_init ? svsx_pkg::MSG_RETURN_INIT : svsx_pkg::MSG_RETURN_NORMAL;
            next_hold_start = 1'b1;
            next_state      = ST_HOLD;
          end else if (reply_is(first, extra, svsx_pkg::CHAR_NO)) begin
            next_msg   = svsx_pkg::MSG_PROMPT;
            next_state = ST_IDLE;
          end else begin
            next_msg   = svsx_pkg::MSG_ERR_INVALID_PARAM;
            next_state = ST_PROMPT;
          end
        end
      end
      ST_HOLD: begin
        if (hold_done) begin
          next_state = ST_EXIT;
        end
      end
      ST_EXIT: begin
        next_goto  = 1'b1;
        next_state = ST_OUT;
      end
      default: begin
        next_state = ST_OUT;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state     <= ST_OUT;
      exit_init <= 1'b0;
    end else begin
      state     <= next_state;
      exit_init <= next_exit_init;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_msg_valid <= 1'b0;
      o_msg       <= svsx_pkg::MSG_PROMPT;
    end else begin
      o_msg_valid <= next_msg_valid;
      o_msg       <= next_msg;
    end
  end

  // Counter saturates rather than wrapping, so the wear warning never clears itself
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_save_count <= svsx_pkg::SAVE_COUNT_RESET;
    end else if (next_count_inc && o_save_count != svsx_pkg::SAVE_COUNT_SAT) begin
      o_save_count <= o_save_count + 16'h0001;
    end else if (i_count_load && state == ST_OUT) begin
      o_save_count <= i_count_value;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_flash_write  <= 1'b0;
      o_revert_tx    <= 1'b0;
      o_goto_normal  <= 1'b0;
      o_goto_init    <= 1'b0;
      o_reload_flash <= 1'b0;
      o_in_service   <= 1'b0;
    end else begin
      o_flash_write  <= next_flash_write;
      o_revert_tx    <= next_revert_tx;
      o_goto_normal  <= next_goto && !exit_init;
      o_goto_init    <= next_goto && exit_init;
      o_reload_flash <= next_goto && exit_init;
      o_in_service   <= next_state != ST_OUT;
    end
  end

  property p_save_yes_writes;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_SAVE_CONF && line_valid && first == svsx_pkg::CHAR_YES && extra == svsx_pkg::EXTRA_NONE)
      |=> o_flash_write && state == ST_FLASH;
  endproperty
  a_save_yes_writes: assert property (p_save_yes_writes) else $error("confirmed save did not write flash");

  property p_save_other_aborts;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_SAVE_CONF && line_valid && !(first == svsx_pkg::CHAR_YES && extra == svsx_pkg::EXTRA_NONE))
      |=> !o_flash_write && o_msg_valid && o_msg == svsx_pkg::MSG_SAVE_ABORTED && o_revert_tx == $past(i_tx_changed);
  endproperty
  a_save_other_aborts: assert property (p_save_other_aborts) else $error("unconfirmed save not aborted");

  property p_save_extra_chars;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_IDLE && line_valid && first == svsx_pkg::CHAR_CMD_SAVE && extra != svsx_pkg::EXTRA_NONE)
      |=> o_msg == svsx_pkg::MSG_ERR_PARAM_COUNT ##1 o_msg == svsx_pkg::MSG_PROMPT;
  endproperty
  a_save_extra_chars: assert property (p_save_extra_chars) else $error("save with arguments not rejected");

  property p_flash_fail;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_FLASH && i_flash_done && !i_flash_ok)
      |=> o_msg_valid && o_msg == svsx_pkg::MSG_ERR_SAVE_FAILED && $stable(o_save_count);
  endproperty
  a_flash_fail: assert property (p_flash_fail) else $error("flash failure not reported");

  property p_lower_y_invalid;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_SAVE_CONF && line_valid && first == svsx_pkg::CHAR_EXIT_NORMAL + 8'h0b)
      |=> o_msg == svsx_pkg::MSG_SAVE_ABORTED ##1 o_msg == svsx_pkg::MSG_ERR_INVALID_PARAM;
  endproperty
  a_lower_y_invalid: assert property (p_lower_y_invalid) else $error("lower-case reply not flagged");

  property p_count_step;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_FLASH && i_flash_done && i_flash_ok && o_save_count != svsx_pkg::SAVE_COUNT_SAT)
      |=> o_save_count == $past(o_save_count) + 16'h0001 ##1 o_msg == svsx_pkg::MSG_SAVE_COUNT;
  endproperty
  a_count_step: assert property (p_count_step) else $error("save counter not advanced");

  property p_wear_warning;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_SAVE_COUNT && o_save_count > svsx_pkg::SAVE_COUNT_MAX)
      |=> ##1 o_msg_valid && o_msg == svsx_pkg::MSG_WARN_MAX_SAVES;
  endproperty
  a_wear_warning: assert property (p_wear_warning) else $error("wear warning missing");

  property p_exit_now;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_IDLE && line_valid && first == svsx_pkg::CHAR_CMD_EXIT && extra == svsx_pkg::EXTRA_EXIT
       && second == svsx_pkg::CHAR_SPACE && third == svsx_pkg::CHAR_EXIT_NORMAL_NOW)
      |=> o_msg == svsx_pkg::MSG_RETURN_NORMAL ##1 o_goto_normal && !o_goto_init;
  endproperty
  a_exit_now: assert property (p_exit_now) else $error("immediate exit not taken");

  property p_exit_conf_no;
    @(posedge i_clock) disable iff (i_rst)
      (state == ST_EXIT_CONF && line_valid && first == svsx_pkg::CHAR_NO && extra == svsx_pkg::EXTRA_NONE)
      |=> o_msg == svsx_pkg::MSG_PROMPT && o_in_service [*2];
  endproperty
  a_exit_conf_no: assert property (p_exit_conf_no) else $error("declined exit left Service Mode");

  property p_init_reload;
    @(posedge i_clock) disable iff (i_rst)
      o_goto_init |-> o_reload_flash && !o_in_service;
  endproperty
  a_init_reload: assert property (p_init_reload) else $error("Init Mode entered without reload");

  c_save_ok: cover property (@(posedge i_clock) disable iff (i_rst) state == ST_SAVE_COUNT);
  c_save_warn: cover property (@(posedge i_clock) disable iff (i_rst) state == ST_SAVE_WARN);
  c_exit_hold: cover property (@(posedge i_clock) disable iff (i_rst) state == ST_HOLD ##1 state == ST_EXIT);
  c_exit_init: cover property (@(posedge i_clock) disable iff (i_rst) o_goto_init);

endmodule

// ===== tb/svsx_flash_model.sv
// Flash partner: answers each write request after a short delay
`timescale 1ns/1ps
module svsx_flash_model (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // Request and result
  input  wire logic i_write,
  input  wire logic i_fail,
  output logic      o_done,
  output logic      o_ok
);
  logic [3:0] wait_cnt;
  logic       busy;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (i_write) begin
      busy <= 1'b1;
      wait_cnt <= 4'h5;
    end else if (busy) begin
      wait_cnt <= wait_cnt - 4'h1;
      busy <= (wait_cnt != 4'h0);
    end
  end
  // Result toggles outside the done pulse so nothing can lean on a stale value
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_done <= 1'b0;
      o_ok <= 1'b0;
    end else begin
      o_done <= busy && (wait_cnt == 4'h0);
      o_ok <= (busy && (wait_cnt == 4'h0)) ? !i_fail : !o_ok;
    end
  end
endmodule

// ===== tb/service_mode_save_exit_bench.sv
// Self-checking bench for the save and exit command handler
`timescale 1ns/1ps
module service_mode_save_exit_bench;
  localparam int unsigned HOLD = 20;
  logic                i_clock = 1'b0;
  logic                i_rst = 1'b1;
  logic                i_rx_valid = 1'b0;
  logic [7:0]          i_rx_data = 8'h00;
  logic                i_enter_service = 1'b0;
  logic                i_params_differ = 1'b0;
  logic                i_tx_changed = 1'b0;
  logic                i_count_load = 1'b0;
  logic [15:0]         i_count_value = 16'h0000;
  logic                flash_fail = 1'b0;
  logic                o_flash_write, i_flash_done, i_flash_ok, o_msg_valid, o_revert_tx;
  logic                o_goto_normal, o_goto_init, o_reload_flash, o_in_service, go_init, go_reload;
  logic [15:0]         o_save_count;
  svsx_pkg::svsx_msg_e o_msg;
  svsx_pkg::svsx_msg_e mq[$];
  int                  cyc = 0, t_msg = 0, t_go = 0, n_go = 0, n_rev = 0, n_wr = 0;
  int                  miscompares = 0, num_checks = 0;

  always #4 i_clock = ~i_clock;

  svsx_cmd_handler #(.P_HOLD_CYCLES(HOLD)) uut (.i_clock(i_clock), .i_rst(i_rst), .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data), .i_enter_service(i_enter_service), .i_params_differ(i_params_differ),
    .i_tx_changed(i_tx_changed), .i_count_load(i_count_load), .i_count_value(i_count_value),
    .o_flash_write(o_flash_write), .i_flash_done(i_flash_done), .i_flash_ok(i_flash_ok),
    .o_msg_valid(o_msg_valid), .o_msg(o_msg), .o_save_count(o_save_count), .o_revert_tx(o_revert_tx),
    .o_goto_normal(o_goto_normal), .o_goto_init(o_goto_init), .o_reload_flash(o_reload_flash),
    .o_in_service(o_in_service));
  svsx_flash_model flash (.i_clock(i_clock), .i_rst(i_rst), .i_write(o_flash_write), .i_fail(flash_fail),
    .o_done(i_flash_done), .o_ok(i_flash_ok));

  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (o_msg_valid === 1'b1) begin
      mq.push_back(o_msg);
      t_msg <= cyc;
    end
    if (o_goto_normal === 1'b1 || o_goto_init === 1'b1) begin
      t_go <= cyc;
      n_go <= n_go + 1;
      go_init <= o_goto_init;
      go_reload <= o_reload_flash;
    end
    if (o_revert_tx === 1'b1) n_rev <= n_rev + 1;
    if (o_flash_write === 1'b1) n_wr <= n_wr + 1;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (exp !== got) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic give_up();
    miscompares++;
    $display("wrong value wait expected event seen timeout");
    print_verdict();
  endtask
  // Waits for the next response item; a hang ends the run
  task automatic want(svsx_pkg::svsx_msg_e e);
    int n;
    n = 0;
    while (mq.size() == 0 && n < 300) begin
      @(negedge i_clock);
      n++;
    end
    if (mq.size() == 0) give_up();
    chk("msg", 16'(e), 16'(mq.pop_front()));
  endtask
  task automatic send(string s);
    for (int k = 0; k <= s.len(); k++) begin
      @(negedge i_clock);
      i_rx_valid = 1'b1;
      i_rx_data = (k == s.len()) ? svsx_pkg::CHAR_CR : 8'(s[k]);
    end
    @(negedge i_clock);
    i_rx_valid = 1'b0;
  endtask
  task automatic line_err(string s, svsx_pkg::svsx_msg_e e);
    send(s);
    want(e);
    want(svsx_pkg::MSG_PROMPT);
  endtask
  task automatic enter();
    @(negedge i_clock);
    i_enter_service = 1'b1;
    @(negedge i_clock);
    i_enter_service = 1'b0;
    want(svsx_pkg::MSG_PROMPT);
    chk("in_service", 16'h0001, 16'(o_in_service));
  endtask
  // Announcement, then the mode pulse after the hold time or on the very next cycle
  task automatic go(svsx_pkg::svsx_msg_e e, logic init, logic hold);
    int n, g;
    g = n_go;
    want(e);
    n = 0;
    while (n_go == g && n < HOLD + 50) begin
      @(negedge i_clock);
      n++;
    end
    if (n_go == g) give_up();
    if (hold) chk("hold", 16'h0001, 16'(t_go - t_msg >= HOLD));
    else chk("gap", 16'h0001, 16'(t_go - t_msg));
    chk("to_init", 16'(init), 16'(go_init));
    chk("reload", 16'(init), 16'(go_reload));
    chk("in_service", 16'h0000, 16'(o_in_service));
    chk("no_prompt", 16'h0000, 16'(mq.size()));
  endtask

  task automatic sc_save_warn();
    send("s");
    want(svsx_pkg::MSG_SAVE_CONFIRM);
    send("Y");
    want(svsx_pkg::MSG_SAVE_STORED);
    want(svsx_pkg::MSG_SAVE_COUNT);
    chk("count", 16'h2711, o_save_count);
    want(svsx_pkg::MSG_WARN_MAX_SAVES);
    want(svsx_pkg::MSG_PROMPT);
    chk("writes", 16'h0001, 16'(n_wr));
  endtask
  task automatic sc_save_fail();
    flash_fail = 1'b1;
    send("s");
    want(svsx_pkg::MSG_SAVE_CONFIRM);
    send("Y");
    want(svsx_pkg::MSG_ERR_SAVE_FAILED);
    want(svsx_pkg::MSG_PROMPT);
    chk("writes", 16'h0002, 16'(n_wr));
    chk("count", 16'h2711, o_save_count);
    flash_fail = 1'b0;
  endtask
  task automatic sc_save_abort();
    i_tx_changed = 1'b1;
    send("s");
    want(svsx_pkg::MSG_SAVE_CONFIRM);
    line_err("N", svsx_pkg::MSG_SAVE_ABORTED);
    chk("revert", 16'h0001, 16'(n_rev));
    send("s");
    want(svsx_pkg::MSG_SAVE_CONFIRM);
    send("y");
    want(svsx_pkg::MSG_SAVE_ABORTED);
    want(svsx_pkg::MSG_ERR_INVALID_PARAM);
    want(svsx_pkg::MSG_PROMPT);
    chk("revert", 16'h0002, 16'(n_rev));
    chk("writes", 16'h0002, 16'(n_wr));
    i_tx_changed = 1'b0;
  endtask
  task automatic sc_errors();
    line_err("s1", svsx_pkg::MSG_ERR_PARAM_COUNT);
    line_err("q", svsx_pkg::MSG_ERR_UNKNOWN_CMD);
    line_err("x q", svsx_pkg::MSG_ERR_INVALID_PARAM);
    line_err("x,n", svsx_pkg::MSG_ERR_PARAM_COUNT);
    line_err("x", svsx_pkg::MSG_ERR_PARAM_COUNT);
    line_err("x n n", svsx_pkg::MSG_ERR_PARAM_COUNT);
  endtask
  task automatic sc_exit_confirm();
    i_params_differ = 1'b1;
    send("x n");
    want(svsx_pkg::MSG_EXIT_CONFIRM);
    send("N");
    want(svsx_pkg::MSG_PROMPT);
    send("x i");
    want(svsx_pkg::MSG_EXIT_CONFIRM);
    line_err("n", svsx_pkg::MSG_ERR_INVALID_PARAM);
    chk("in_service", 16'h0001, 16'(o_in_service));
    send("x i");
    want(svsx_pkg::MSG_EXIT_CONFIRM);
    send("Y");
    go(svsx_pkg::MSG_RETURN_INIT, 1'b1, 1'b1);
  endtask
  task automatic sc_exit_direct();
    enter();
    send("x N");
    go(svsx_pkg::MSG_RETURN_NORMAL, 1'b0, 1'b0);
    enter();
    send("x I");
    go(svsx_pkg::MSG_RETURN_INIT, 1'b1, 1'b0);
    i_params_differ = 1'b0;
    enter();
    send("x n");
    go(svsx_pkg::MSG_RETURN_NORMAL, 1'b0, 1'b1);
  endtask

  initial begin
    repeat (6) @(negedge i_clock);
    i_rst = 1'b0;
    i_count_load = 1'b1;
    i_count_value = 16'h2710;
    @(negedge i_clock);
    i_count_load = 1'b0;
    enter();
    sc_save_warn();
    sc_save_fail();
    sc_save_abort();
    sc_errors();
    sc_exit_confirm();
    sc_exit_direct();
    print_verdict();
  end
endmodule
